// ===== dv/tcp_timer_monitor.sv
// concurrent checks on the timer's register port, interrupt requests and compare pins
`timescale 1ns/1ps
`default_nettype none
module tcp_timer_monitor
    import tcp_pkg::*;
(
    input wire logic       MCLK,
    input wire logic       SYS_RST,
    input wire logic [3:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    input wire logic       REG_WR,
    input wire logic       REG_RD,
    input wire logic [7:0] REG_RDATA,
    input wire logic       EXTERNAL_CLOCK_PIN,
    input wire logic [2:0] IRQ_ACK,
    input wire logic [2:0] IRQ_REQ,
    input wire logic       COMPARE_OUTPUT_A,
    input wire logic       COMPARE_OUTPUT_B,
    input wire logic       COMPARE_DRIVE_A,
    input wire logic       COMPARE_DRIVE_B
);
    logic [2:0] mask_q;
    logic [2:0] mask_p;

    // shadow mask, one cycle old too, though the request follows a mask clear in the same cycle
    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) {mask_q, mask_p} <= 6'h00;
        else if (REG_WR && REG_ADDR == ADDR_INT_MASK) {mask_q, mask_p} <= {REG_WDATA[2:0], mask_q};
        else mask_p <= mask_q;
    end

    // port relations; reset check has no disable since it watches reset itself
    a_reset_quiet: assert property (@(posedge MCLK) SYS_RST |=>
        IRQ_REQ == 3'h0 && REG_RDATA == 8'h00 && !COMPARE_DRIVE_A && !COMPARE_DRIVE_B) else $error("outputs busy in reset");
    a_read_idle: assert property (@(posedge MCLK) disable iff (SYS_RST)
        !$past(REG_RD) |-> REG_RDATA == 8'h00) else $error("read data outside read slot");
    a_strobe_reads_zero: assert property (@(posedge MCLK) disable iff (SYS_RST)
        $past(REG_RD && (REG_ADDR == ADDR_CONTROL_C || REG_ADDR > ADDR_POWER)) |-> REG_RDATA == 8'h00) else $error("bad read");
    a_irq_masked: assert property (@(posedge MCLK) disable iff (SYS_RST)
        (IRQ_REQ & ~(mask_q | mask_p)) == 3'h0) else $error("request through a masked bit");
    a_drive_a_cause: assert property (@(posedge MCLK) disable iff (SYS_RST) $changed(COMPARE_DRIVE_A) |->
        $past(REG_WR && REG_ADDR == ADDR_CONTROL_A) || $past(REG_WR && REG_ADDR == ADDR_CONTROL_A, 2)) else $error("drive a");
    a_drive_b_follows: assert property (@(posedge MCLK) disable iff (SYS_RST)
        REG_WR && REG_ADDR == ADDR_CONTROL_A && REG_WDATA[5:4] != 2'h0 |-> ##[1:2] COMPARE_DRIVE_B) else $error("drive b");
    a_hold_a_off: assert property (@(posedge MCLK) disable iff (SYS_RST)
        !COMPARE_DRIVE_A && $past(!COMPARE_DRIVE_A) && $past(!COMPARE_DRIVE_A, 2) |-> $stable(COMPARE_OUTPUT_A)) else $error("out a");
    a_hold_b_off: assert property (@(posedge MCLK) disable iff (SYS_RST)
        !COMPARE_DRIVE_B && $past(!COMPARE_DRIVE_B) && $past(!COMPARE_DRIVE_B, 2) |-> $stable(COMPARE_OUTPUT_B)) else $error("out b");
endmodule : tcp_timer_monitor
`default_nettype wire

// ===== dv/test_tcp_timer.sv
// self-checking bench for the 8-bit timer/counter through its register port and pins
`timescale 1ns/1ps
`default_nettype none
module test_tcp_timer
    import tcp_pkg::*;
;
    logic       MCLK = 1'b0, SYS_RST = 1'b1, REG_WR = 1'b0, REG_RD = 1'b0, EXTERNAL_CLOCK_PIN = 1'b0;
    logic [3:0] REG_ADDR = 4'h0;
    logic [7:0] REG_WDATA = 8'h00;
    logic [2:0] IRQ_ACK = 3'h0;
    logic [7:0] REG_RDATA;
    logic [2:0] IRQ_REQ;
    logic       COMPARE_OUTPUT_A, COMPARE_OUTPUT_B, COMPARE_DRIVE_A, COMPARE_DRIVE_B;
    int         fails = 0, n_compared = 0, cycles = 0;

    tcp_timer dut (.*);

    // system clock and a hang guard well above the few hundred cycles the tests need
    initial begin
        forever #2 MCLK = ~MCLK;
    end
    always @(posedge MCLK) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            fails = fails + 1;
            final_report();
        end
    end

    task automatic final_report();
        $display("compared %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : final_report

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // one-cycle strobes; each task ends one edge after lowering so calls never collide
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        REG_WR <= 1'b1;
        REG_ADDR <= a;
        REG_WDATA <= d;
        @(posedge MCLK);
        REG_WR <= 1'b0;
        @(posedge MCLK);
    endtask : wr

    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        REG_RD <= 1'b1;
        REG_ADDR <= a;
        @(posedge MCLK);
        REG_RD <= 1'b0;
        #1 chk(REG_RDATA, exp);
        @(posedge MCLK);
    endtask : rd

    // main sequence
    initial begin
        repeat (8) @(posedge MCLK);
        SYS_RST <= 1'b0;
        @(posedge MCLK);
        for (int a = 0; a <= 9; a++) rd(a[3:0], 8'h00);
        wr(ADDR_COUNT, 8'hA5);
        repeat (20) @(posedge MCLK);
        rd(ADDR_COUNT, 8'hA5);
        wr(ADDR_POWER, 8'h01);
        wr(ADDR_CONTROL_B, 8'h01);
        repeat (20) @(posedge MCLK);
        rd(ADDR_COUNT, 8'hA5);
        wr(ADDR_CONTROL_B, 8'h00);
        wr(ADDR_POWER, 8'h00);
        $display("stopped and powered-off test done");
        // compares parked far away so only the wrap can raise a flag
        wr(ADDR_COMPARE_A, 8'h80);
        wr(ADDR_COMPARE_B, 8'h80);
        wr(ADDR_INT_MASK, 8'h06);
        wr(ADDR_COUNT, 8'hFE);
        wr(ADDR_CONTROL_B, 8'h01);
        repeat (10) @(posedge MCLK);
        wr(ADDR_CONTROL_B, 8'h00);
        rd(ADDR_INT_FLAGS, 8'h01);
        #1 chk({5'h0, IRQ_REQ}, 8'h00);
        wr(ADDR_INT_MASK, 8'h07);
        #1 chk({5'h0, IRQ_REQ}, 8'h01);
        wr(ADDR_INT_FLAGS, 8'h06);
        rd(ADDR_INT_FLAGS, 8'h01);
        wr(ADDR_INT_FLAGS, 8'h01);
        rd(ADDR_INT_FLAGS, 8'h00);
        $display("overflow test done");
        // top at 5 keeps the count off compare b at 6
        wr(ADDR_COUNT, 8'h00);
        wr(ADDR_COMPARE_A, 8'h05);
        wr(ADDR_COMPARE_B, 8'h06);
        wr(ADDR_CONTROL_A, 8'h42);
        wr(ADDR_CONTROL_B, 8'h01);
        for (int i = 0; i < 600 && IRQ_REQ[1] !== 1'b1; i++) @(posedge MCLK);
        #1 chk({7'h0, IRQ_REQ[1]}, 8'h01);
        repeat (30) @(posedge MCLK);
        wr(ADDR_CONTROL_B, 8'h00);
        rd(ADDR_INT_FLAGS, 8'h02);
        IRQ_ACK <= 3'h2;
        @(posedge MCLK);
        IRQ_ACK <= 3'h0;
        #1 chk({5'h0, IRQ_REQ}, 8'h00);
        chk({7'h0, COMPARE_DRIVE_A}, 8'h01);
        $display("clear-on-compare test done");
        wr(ADDR_COUNT, 8'h33);
        wr(ADDR_CONTROL_A, 8'hD2);
        wr(ADDR_CONTROL_C, 8'h80);
        #1 chk({7'h0, COMPARE_OUTPUT_A}, 8'h01);
        wr(ADDR_CONTROL_C, 8'h40);
        #1 chk({7'h0, COMPARE_OUTPUT_B}, 8'h01);
        wr(ADDR_CONTROL_A, 8'h82);
        wr(ADDR_CONTROL_C, 8'h80);
        #1 chk({7'h0, COMPARE_OUTPUT_A}, 8'h00);
        rd(ADDR_INT_FLAGS, 8'h00);
        rd(ADDR_COUNT, 8'h33);
        $display("force test done");
        wr(ADDR_CONTROL_A, 8'h03);
        wr(ADDR_COMPARE_A, 8'h99);
        wr(ADDR_CONTROL_A, 8'h00);
        rd(ADDR_COMPARE_A, 8'h05);
        for (int c = 6; c <= 7; c++) begin
            wr(ADDR_COUNT, 8'h00);
            wr(ADDR_CONTROL_B, c[7:0]);
            repeat (4) begin
                EXTERNAL_CLOCK_PIN <= 1'b1;
                repeat (8) @(posedge MCLK);
                EXTERNAL_CLOCK_PIN <= 1'b0;
                repeat (8) @(posedge MCLK);
            end
            wr(ADDR_CONTROL_B, 8'h00);
            rd(ADDR_COUNT, 8'h04);
        end
        $display("external clock test done");
        // the count write must swallow the match at the written value
        wr(ADDR_COMPARE_B, 8'h10);
        wr(ADDR_COUNT, 8'h10);
        wr(ADDR_CONTROL_B, 8'h01);
        repeat (20) @(posedge MCLK);
        wr(ADDR_CONTROL_B, 8'h00);
        rd(ADDR_INT_FLAGS, 8'h00);
        $display("match blocking test done");
        final_report();
    end
endmodule : test_tcp_timer

bind tcp_timer tcp_timer_monitor mon (.*);
`default_nettype wire

// ===== rtl/tcp_timer.sv
// 8-bit timer/counter with two compare channels, prescaler and external clock
//
// Decided for this implementation: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// R1: a count of zero is bottom, flagged internally whenever the count is zero.
// R2: all ones, 0xFF, is the maximum count.
// R3: top is either the maximum or compare register A, chosen by mode.
// R4: three-bit clock select; zero selects nothing and the counter stays stopped.
// R5: tick comes from the internal prescaler or the external pin, edge selectable.
// R6: each tick clears, increments or decrements the count as the mode needs.
// R7: software may read and write the count at any time.
// R8: a software count write beats any clear or step in the same cycle.
// R9: three-bit mode, two bits in control A, top bit in control B.
// R10: overflow flag set where the mode says and may request an interrupt.
// R11: each channel compares count with its compare value all the time.
// R12: a match sets that channel's flag on the tick; mask enables its request.
// R13: the flag clears itself when the interrupt is acknowledged.
// R14: writing one to a flag clears it; writing zero leaves it.
// R15: three flags in one flag register, each gated by its own mask bit.
// R16: in pwm modes compare writes go to a buffer copied at top or bottom.
// R17: in normal and ctc modes compare registers are written directly.
// R18: in non-pwm modes a force strobe acts on the output as a real match.
// R19: a forced compare sets no flag and does not clear the counter.
// R20: output derived from match, mode and output mode, plus max and bottom.
// R21: the timer runs only while its power-off bit is zero.
// R22: a count write blocks compare matches on the following tick.
// R23: normal mode counts up, wraps max to zero, flags overflow on the wrap.
// R24: ctc mode clears the count when it equals compare A, which is top.
// R25: output mode zero takes no action on the output state.
// R26: reset clears count, compares, controls, flags and mask; timer stopped.
// R27: the external pin is synchronised and edge detected before use.
module tcp_timer
    import tcp_pkg::*;
(
    input  wire logic       MCLK,
    input  wire logic       SYS_RST,
    input  wire logic [3:0] REG_ADDR,
    input  wire logic [7:0] REG_WDATA,
    input  wire logic       REG_WR,
    input  wire logic       REG_RD,
    output var  logic [7:0] REG_RDATA,
    input  wire logic       EXTERNAL_CLOCK_PIN,
    input  wire logic [2:0] IRQ_ACK,
    output var  logic [2:0] IRQ_REQ,
    output var  logic       COMPARE_OUTPUT_A,
    output var  logic       COMPARE_OUTPUT_B,
    output var  logic       COMPARE_DRIVE_A,
    output var  logic       COMPARE_DRIVE_B
);

    // true in the phase-correct and fast pwm modes
    function automatic logic is_pwm(input tcp_wgm_t m);
        return (m == TCP_WGM_PC_MAX) || (m == TCP_WGM_FAST_MAX) ||
               (m == TCP_WGM_PC_OCRA) || (m == TCP_WGM_FAST_OCRA);
    endfunction : is_pwm

    // true in the single-slope pwm modes
    function automatic logic is_fast(input tcp_wgm_t m);
        return (m == TCP_WGM_FAST_MAX) || (m == TCP_WGM_FAST_OCRA);
    endfunction : is_fast

    // register write decode, shared by every writable register
    function automatic logic wr_hit(input logic wr, input tcp_addr_t a, input tcp_addr_t target);
        return wr && (a == target);
    endfunction : wr_hit

    // control state
    tcp_wgm_t    wgm;
    tcp_cs_t     cs;
    logic        power_off;
    logic [2:0]  mask;
    logic [2:0]  flags;
    tcp_byte_t   count;
    tcp_dir_t    dir;
    logic        block;
    tcp_chan_t   chan [2];
    tcp_byte_t   rdata;
    logic [2:0]  irq;

    tcp_wgm_t    next_wgm;
    tcp_cs_t     next_cs;
    logic        next_power_off;
    logic [2:0]  next_mask;
    logic [2:0]  next_flags;
    tcp_byte_t   next_count;
    tcp_dir_t    next_dir;
    logic        next_block;
    tcp_chan_t   next_chan [2];
    tcp_byte_t   next_rdata;
    logic [2:0]  next_irq;

    // tick source state
    logic [9:0]  pre;
    logic        sync_a;
    logic        sync_b;
    logic        pin_last;
    logic        tick;
    logic [9:0]  next_pre;
    logic        next_sync_a;
    logic        next_sync_b;
    logic        next_pin_last;
    logic        next_tick;

    // combinational helpers
    logic        active;
    tcp_byte_t   top;
    logic        at_bottom;
    logic        at_max;
    logic        at_top;
    logic [1:0]  raw_match;
    logic [1:0]  match;

    assign active    = (cs != TCP_CS_NONE) && !power_off;                    // R4 R21
    assign top       = (wgm == TCP_WGM_CTC || wgm == TCP_WGM_PC_OCRA ||
                        wgm == TCP_WGM_FAST_OCRA) ? chan[0].active : MAX_VALUE; // R3
    assign at_bottom = (count == BOTTOM_VALUE);                              // R1
    assign at_max    = (count == MAX_VALUE);                                 // R2
    assign at_top    = (count == top);

    // one comparator per channel; a pending count write masks the match
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_cmp
            assign raw_match[g] = (count == chan[g].active);                 // R11
            assign match[g]     = tick && raw_match[g] && !block;           // R22
        end
    endgenerate

    // tick source: prescaler taps or synchronised external edge
    always_comb begin : tick_next
        next_pre      = active ? pre + PRE_ONE : PRE_ZERO;
        next_sync_a   = EXTERNAL_CLOCK_PIN;                                  // R27
        next_sync_b   = sync_a;
        next_pin_last = sync_b;
        next_tick     = 1'b0;
        if (active) begin
            case (cs)
                TCP_CS_DIV1:     next_tick = 1'b1;                           // R5
                TCP_CS_DIV8:     next_tick = (pre & PRE_MASK_8) == PRE_MASK_8;
                TCP_CS_DIV64:    next_tick = (pre & PRE_MASK_64) == PRE_MASK_64;
                TCP_CS_DIV256:   next_tick = (pre & PRE_MASK_256) == PRE_MASK_256;
                TCP_CS_DIV1024:  next_tick = (pre & PRE_MASK_1K) == PRE_MASK_1K;
                TCP_CS_EXT_FALL: next_tick = pin_last && !sync_b;            // R27
                TCP_CS_EXT_RISE: next_tick = !pin_last && sync_b;            // R27
                default:         next_tick = 1'b0;                           // R4
            endcase
        end
    end

    // the tick is registered, so a tick lasts exactly one system clock
    always_ff @(posedge MCLK or posedge SYS_RST) begin : tick_regs
        if (SYS_RST) begin
            pre      <= PRE_ZERO;
            sync_a   <= 1'b0;
            sync_b   <= 1'b0;
            pin_last <= 1'b0;
            tick     <= 1'b0;
        end else begin
            pre      <= next_pre;
            sync_a   <= next_sync_a;
            sync_b   <= next_sync_b;
            pin_last <= next_pin_last;
            tick     <= next_tick;
        end
    end

    // registers, counter, flags and waveform generators
    always_comb begin : core_next
        logic [1:0] force_hit;
        logic       buf_load;
        logic [2:0] set_ev;
        logic [2:0] clr_ev;
        force_hit  = 2'b00;
        buf_load   = 1'b0;
        set_ev     = 3'b000;
        clr_ev     = 3'b000;
        next_wgm   = wgm;
        next_cs    = cs;
        next_power_off = power_off;
        next_mask  = mask;
        next_count = count;
        next_dir   = dir;
        next_block = block;
        next_chan  = chan;
        next_rdata = RESET_BYTE;

        // counter sequence on each tick
        if (tick) begin
            next_block = 1'b0;                                               // R22
            case (wgm)
                TCP_WGM_CTC: begin
                    next_count = raw_match[0] ? BOTTOM_VALUE : count + ONE_BYTE; // R24 R6
                    set_ev[INT_OVF] = at_max;
                end
                TCP_WGM_FAST_MAX, TCP_WGM_FAST_OCRA: begin
                    next_count = at_top ? BOTTOM_VALUE : count + ONE_BYTE;   // R6
                    set_ev[INT_OVF] = at_top;                                // R10
                    buf_load = at_top;                                       // R16
                end
                TCP_WGM_PC_MAX, TCP_WGM_PC_OCRA: begin
                    if (dir == TCP_DIR_UP) begin
                        if (at_top) begin
                            next_dir   = TCP_DIR_DOWN;
                            next_count = at_bottom ? count : count - ONE_BYTE; // R6
                            buf_load   = 1'b1;                               // R16
                        end else begin
                            next_count = count + ONE_BYTE;
                        end
                    end else begin
                        if (at_bottom) begin
                            next_dir   = TCP_DIR_UP;
                            next_count = count + ONE_BYTE;
                            set_ev[INT_OVF] = 1'b1;                          // R10
                        end else begin
                            next_count = count - ONE_BYTE;
                        end
                    end
                end
                default: begin
                    // normal and reserved codes: plain up counter with wrap
                    next_count = count + ONE_BYTE;                           // R23
                    set_ev[INT_OVF] = at_max;                                // R23
                end
            endcase
            if (!is_pwm(wgm)) begin
                next_dir = TCP_DIR_UP;
            end
        end
        set_ev[INT_CMP_A] = match[0];                                        // R12
        set_ev[INT_CMP_B] = match[1];                                        // R12

        // buffered compare copied into the active register
        if (buf_load && is_pwm(wgm)) begin
            next_chan[0].active = chan[0].buffer;                            // R16
            next_chan[1].active = chan[1].buffer;                            // R16
        end

        // register writes; a count write wins over the sequence above
        if (wr_hit(REG_WR, REG_ADDR, ADDR_CONTROL_A)) begin
            next_chan[0].com = REG_WDATA[CA_COM_A_LSB +: 2];
            next_chan[1].com = REG_WDATA[CA_COM_B_LSB +: 2];
            next_wgm = tcp_wgm_t'({wgm[2], REG_WDATA[CA_WGM_LSB +: 2]});     // R9
        end
        if (wr_hit(REG_WR, REG_ADDR, ADDR_CONTROL_B)) begin
            next_wgm = tcp_wgm_t'({REG_WDATA[CB_WGM_MSB], wgm[1:0]});        // R9
            next_cs  = tcp_cs_t'(REG_WDATA[CB_CS_LSB +: 3]);                 // R4
        end
        if (wr_hit(REG_WR, REG_ADDR, ADDR_CONTROL_C) && !is_pwm(wgm)) begin
            force_hit[0] = REG_WDATA[CC_FORCE_A];                            // R18
            force_hit[1] = REG_WDATA[CC_FORCE_B];                            // R18
        end
        if (wr_hit(REG_WR, REG_ADDR, ADDR_COUNT)) begin
            next_count = REG_WDATA;                                          // R7 R8
            next_block = 1'b1;                                               // R22
        end
        if (wr_hit(REG_WR, REG_ADDR, ADDR_COMPARE_A)) begin
            next_chan[0].buffer = REG_WDATA;                                 // R16
            if (!is_pwm(wgm)) begin
                next_chan[0].active = REG_WDATA;                             // R17
            end
        end
        if (wr_hit(REG_WR, REG_ADDR, ADDR_COMPARE_B)) begin
            next_chan[1].buffer = REG_WDATA;                                 // R16
            if (!is_pwm(wgm)) begin
                next_chan[1].active = REG_WDATA;                             // R17
            end
        end
        if (wr_hit(REG_WR, REG_ADDR, ADDR_INT_MASK)) begin
            next_mask = REG_WDATA[2:0];                                      // R15
        end
        if (wr_hit(REG_WR, REG_ADDR, ADDR_INT_FLAGS)) begin
            clr_ev = REG_WDATA[2:0];                                         // R14
        end
        if (wr_hit(REG_WR, REG_ADDR, ADDR_POWER)) begin
            next_power_off = REG_WDATA[PWR_OFF_BIT];                         // R21
        end

        // flags: a new event wins over a software or acknowledge clear
        clr_ev     = clr_ev | IRQ_ACK;                                       // R13
        next_flags = (flags & ~clr_ev) | set_ev;                             // R14 R15

        // waveform generator per channel
        for (int c = 0; c < 2; c++) begin
            next_chan[c].drive = (next_chan[c].com != COM_OFF);
            if (!is_pwm(wgm)) begin
                // forced compare acts on the output only, never on flag or count
                if (match[c] || force_hit[c]) begin                          // R18 R19
                    case (chan[c].com)
                        COM_TOGGLE: next_chan[c].out = !chan[c].out;         // R20
                        COM_CLEAR:  next_chan[c].out = 1'b0;
                        COM_SET:    next_chan[c].out = 1'b1;
                        default:    next_chan[c].out = chan[c].out;          // R25
                    endcase
                end
            end else if (is_fast(wgm)) begin
                case (chan[c].com)
                    COM_CLEAR: begin
                        if (match[c]) next_chan[c].out = 1'b0;               // R20
                        if (tick && at_top && !(raw_match[c] && at_max && chan[c].active == MAX_VALUE))
                            next_chan[c].out = 1'b1;                         // R20
                    end
                    COM_SET: begin
                        if (match[c]) next_chan[c].out = 1'b1;
                        if (tick && at_top && !(raw_match[c] && at_max && chan[c].active == MAX_VALUE))
                            next_chan[c].out = 1'b0;
                    end
                    COM_TOGGLE: begin
                        if (c == 0 && wgm[2] && match[c]) next_chan[c].out = !chan[c].out;
                    end
                    default: next_chan[c].out = chan[c].out;                 // R25
                endcase
            end else begin
                case (chan[c].com)
                    COM_CLEAR: begin
                        if (match[c]) next_chan[c].out = (dir == TCP_DIR_DOWN);  // R20
                    end
                    COM_SET: begin
                        if (match[c]) next_chan[c].out = (dir == TCP_DIR_UP);
                    end
                    COM_TOGGLE: begin
                        if (c == 0 && wgm[2] && match[c]) next_chan[c].out = !chan[c].out;
                    end
                    default: next_chan[c].out = chan[c].out;                 // R25
                endcase
            end
        end

        // read data, visible in the cycle after the strobe only
        if (REG_RD) begin
            case (REG_ADDR)
                ADDR_CONTROL_A: next_rdata = {chan[0].com, chan[1].com, 2'b00, wgm[1:0]};
                ADDR_CONTROL_B: next_rdata = {4'h0, wgm[2], cs};
                ADDR_COUNT:     next_rdata = count;                          // R7
                ADDR_COMPARE_A: next_rdata = is_pwm(wgm) ? chan[0].buffer : chan[0].active;
                ADDR_COMPARE_B: next_rdata = is_pwm(wgm) ? chan[1].buffer : chan[1].active;
                ADDR_INT_MASK:  next_rdata = {5'h00, mask};
                ADDR_INT_FLAGS: next_rdata = {5'h00, flags};                 // R15
                ADDR_POWER:     next_rdata = {7'h00, power_off};
                default:        next_rdata = RESET_BYTE;                     // strobe register reads zero
            endcase
        end

        next_irq = next_flags & next_mask;                                   // R15 R12 R10
    end

    // everything clears on reset so the timer starts stopped
    always_ff @(posedge MCLK or posedge SYS_RST) begin : core_regs
        if (SYS_RST) begin
            wgm       <= TCP_WGM_NORMAL;                                     // R26
            cs        <= TCP_CS_NONE;
            power_off <= 1'b0;
            mask      <= 3'b000;
            flags     <= 3'b000;
            count     <= RESET_BYTE;
            dir       <= TCP_DIR_UP;
            block     <= 1'b0;
            chan[0]   <= '0;
            chan[1]   <= '0;
            rdata     <= RESET_BYTE;
            irq       <= 3'b000;
        end else begin
            wgm       <= next_wgm;
            cs        <= next_cs;
            power_off <= next_power_off;
            mask      <= next_mask;
            flags     <= next_flags;
            count     <= next_count;
            dir       <= next_dir;
            block     <= next_block;
            chan[0]   <= next_chan[0];
            chan[1]   <= next_chan[1];
            rdata     <= next_rdata;
            irq       <= next_irq;
        end
    end

    // ports straight from flip-flops
    assign REG_RDATA        = rdata;
    assign IRQ_REQ          = irq;
    assign COMPARE_OUTPUT_A = chan[0].out;
    assign COMPARE_OUTPUT_B = chan[1].out;
    assign COMPARE_DRIVE_A  = chan[0].drive;
    assign COMPARE_DRIVE_B  = chan[1].drive;

endmodule : tcp_timer
`default_nettype wire

// ===== shared/tcp_pkg.sv
// shared constants, types and field layout of the 8-bit pwm timer/counter
`default_nettype none
package tcp_pkg;
    typedef logic [7:0] tcp_byte_t;
    typedef logic [3:0] tcp_addr_t;

    // register word indexes on the plain register port
    localparam tcp_addr_t ADDR_CONTROL_A = 4'h0;
    localparam tcp_addr_t ADDR_CONTROL_B = 4'h1;
    localparam tcp_addr_t ADDR_CONTROL_C = 4'h2;
    localparam tcp_addr_t ADDR_COUNT     = 4'h3;
    localparam tcp_addr_t ADDR_COMPARE_A = 4'h4;
    localparam tcp_addr_t ADDR_COMPARE_B = 4'h5;
    localparam tcp_addr_t ADDR_INT_MASK  = 4'h6;
    localparam tcp_addr_t ADDR_INT_FLAGS = 4'h7;
    localparam tcp_addr_t ADDR_POWER     = 4'h8;

    // field positions
    localparam int CA_COM_A_LSB = 6;
    localparam int CA_COM_B_LSB = 4;
    localparam int CA_WGM_LSB   = 0;
    localparam int CB_WGM_MSB   = 3;
    localparam int CB_CS_LSB    = 0;
    localparam int CC_FORCE_A   = 7;
    localparam int CC_FORCE_B   = 6;
    localparam int INT_OVF      = 0;
    localparam int INT_CMP_A    = 1;
    localparam int INT_CMP_B    = 2;
    localparam int PWR_OFF_BIT  = 0;

    // count landmarks and reset values
    localparam tcp_byte_t BOTTOM_VALUE = 8'h00;
    localparam tcp_byte_t MAX_VALUE    = 8'hFF;
    localparam tcp_byte_t RESET_BYTE   = 8'h00;
    localparam tcp_byte_t ONE_BYTE     = 8'h01;

    // waveform generation modes
    typedef enum logic [2:0] {
        TCP_WGM_NORMAL    = 3'b000,
        TCP_WGM_PC_MAX    = 3'b001,
        TCP_WGM_CTC       = 3'b010,
        TCP_WGM_FAST_MAX  = 3'b011,
        TCP_WGM_RSVD4     = 3'b100,
        TCP_WGM_PC_OCRA   = 3'b101,
        TCP_WGM_RSVD6     = 3'b110,
        TCP_WGM_FAST_OCRA = 3'b111
    } tcp_wgm_t;

    // clock select codes
    typedef enum logic [2:0] {
        TCP_CS_NONE     = 3'b000,
        TCP_CS_DIV1     = 3'b001,
        TCP_CS_DIV8     = 3'b010,
        TCP_CS_DIV64    = 3'b011,
        TCP_CS_DIV256   = 3'b100,
        TCP_CS_DIV1024  = 3'b101,
        TCP_CS_EXT_FALL = 3'b110,
        TCP_CS_EXT_RISE = 3'b111
    } tcp_cs_t;

    // counting direction for the phase-correct sequences
    typedef enum logic {
        TCP_DIR_UP   = 1'b0,
        TCP_DIR_DOWN = 1'b1
    } tcp_dir_t;

    // compare output mode codes
    localparam logic [1:0] COM_OFF    = 2'h0;
    localparam logic [1:0] COM_TOGGLE = 2'h1;
    localparam logic [1:0] COM_CLEAR  = 2'h2;
    localparam logic [1:0] COM_SET    = 2'h3;

    // prescaler taps, a tick when the low bits are all ones
    localparam logic [9:0] PRE_ZERO     = 10'h000;
    localparam logic [9:0] PRE_ONE      = 10'h001;
    localparam logic [9:0] PRE_MASK_8   = 10'h007;
    localparam logic [9:0] PRE_MASK_64  = 10'h03F;
    localparam logic [9:0] PRE_MASK_256 = 10'h0FF;
    localparam logic [9:0] PRE_MASK_1K  = 10'h3FF;

    // one compare channel: mode, active and buffered compare, output state
    typedef struct packed {
        logic [1:0] com;
        tcp_byte_t  active;
        tcp_byte_t  buffer;
        logic       out;
        logic       drive;
    } tcp_chan_t;
endpackage : tcp_pkg
`default_nettype wire
